// ---- core/sscm_pkg.sv ----
// Package holding register map, field layouts and constants of the clock block.
package sscm_pkg;

   // APB register byte offsets.
   localparam logic [7:0] SSCM_DIV_OFS   = 8'h00;
   localparam logic [7:0] SSCM_TXCM_OFS  = 8'h04;
   localparam logic [7:0] SSCM_RXCM_OFS  = 8'h08;
   localparam logic [7:0] SSCM_SR_OFS    = 8'h0C;
   localparam logic [7:0] SSCM_IMR_OFS   = 8'h10;
   localparam logic [7:0] SSCM_CTRL_OFS  = 8'h14;
   localparam logic [7:0] SSCM_STAT_OFS  = 8'h18;

   // Divider field layout.
   localparam int          SSCM_DIV_W     = 12;
   localparam logic [11:0] SSCM_DIV_RST   = 12'h000;

   // Clock mode field positions.
   localparam int SSCM_CKS_LSB  = 0;
   localparam int SSCM_CKO_LSB  = 2;
   localparam int SSCM_CKI_BIT  = 5;

   // Status width and reset values.
   localparam int         SSCM_SR_W    = 8;
   localparam logic [7:0] SSCM_IMR_RST = 8'h00;
   localparam logic [2:0] SSCM_CM_RST  = 3'h0;

   // Clock source selections.
   typedef enum logic [1:0] {
      SSCM_SRC_DIV  = 2'h0,
      SSCM_SRC_PEER = 2'h1,
      SSCM_SRC_PAD  = 2'h2
   } sscm_src_t;

   // Clock output modes.
   typedef enum logic [2:0] {
      SSCM_OUT_NONE = 3'h0,
      SSCM_OUT_CONT = 3'h1,
      SSCM_OUT_XFER = 3'h2
   } sscm_out_t;

   // Per-section clock mode.
   typedef struct packed {
      logic      invert;
      sscm_out_t out_mode;
      sscm_src_t src;
   } sscm_cm_t;

   // Per-section pad drive pair.
   typedef struct packed {
      logic o;
      logic oe;
   } sscm_pad_t;

endpackage

// ---- core/sscm_div.sv ----
// Divider making the shared 50% duty divided clock and its edge pulses.
`timescale 1ns/1ps
`default_nettype none
module sscm_div
   import sscm_pkg::*;
(
   input  wire logic                  pclk,
   input  wire logic                  presetn,
   input  wire logic [SSCM_DIV_W-1:0] div,
   output logic                       div_clk,
   output logic                       div_rise,
   output logic                       div_fall
);

   logic [SSCM_DIV_W-1:0] cnt;
   logic                  last;

   // Each phase lasts exactly div master cycles; zero stops everything.
   assign last = (cnt == div - 12'h001);

   // Phase counter and level toggle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt     <= 12'h000;
         div_clk <= 1'b0;
      end else if (div == 12'h000) begin
         cnt     <= 12'h000;
         div_clk <= 1'b0;
      end else if (last || cnt >= div) begin
         cnt     <= 12'h000;
         div_clk <= ~div_clk;
      end else begin
         cnt <= cnt + 12'h001;
      end
   end

   // Edge pulses coincide with the level change.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_rise <= 1'b0;
         div_fall <= 1'b0;
      end else begin
         div_rise <= (div != 12'h000) && (last || cnt >= div) && !div_clk;
         div_fall <= (div != 12'h000) && (last || cnt >= div) && div_clk;
      end
   end

endmodule
`default_nettype wire

// ---- core/sscm_sync.sv ----
// Two-flop synchroniser with edge detection for one clock pad input.
`timescale 1ns/1ps
`default_nettype none
module sscm_sync
   import sscm_pkg::*;
(
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic pad_i,
   output logic      level,
   output logic      rise,
   output logic      fall
);

   logic meta;
   logic sync;

   // The first flop feeds only the second; edges are found after it and
   // registered, so each pulse coincides with the new level as the
   // divider's pulses do.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta  <= 1'b0;
         sync  <= 1'b0;
         level <= 1'b0;
         rise  <= 1'b0;
         fall  <= 1'b0;
      end else begin
         meta  <= pad_i;
         sync  <= meta;
         level <= sync;
         rise  <= sync & ~level;
         fall  <= ~sync & level;
      end
   end

endmodule
`default_nettype wire

// ---- core/sscm_top.sv ----
// Clock management top: APB registers, clock selection, pads, interrupt.
`timescale 1ns/1ps
`default_nettype none
module sscm_top
   import sscm_pkg::*;
(
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [7:0]           paddr,
   input  wire logic [31:0]          pwdata,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [SSCM_SR_W-1:0] status_set,
   input  wire logic                 tx_xfer,
   input  wire logic                 rx_xfer,
   input  wire logic                 tx_clock_pin_i,
   output logic                      tx_clock_pin_o,
   output logic                      tx_clock_pin_oe,
   input  wire logic                 rx_clock_pin_i,
   output logic                      rx_clock_pin_o,
   output logic                      rx_clock_pin_oe,
   output logic                      tx_clk,
   output logic                      tx_clk_rise,
   output logic                      tx_clk_fall,
   output logic                      rx_clk,
   output logic                      rx_clk_rise,
   output logic                      rx_clk_fall,
   output logic                      irq
);

   logic [SSCM_DIV_W-1:0] clock_divider_config;
   sscm_cm_t              tx_clock_mode_config;
   sscm_cm_t              rx_clock_mode_config;
   logic [SSCM_SR_W-1:0]  status;
   logic [SSCM_SR_W-1:0]  mask;
   logic                  wr_en;
   logic                  rd_en;
   logic                  sr_read;
   logic                  div_clk;
   logic                  div_rise;
   logic                  div_fall;
   logic                  txp_lvl;
   logic                  txp_rise;
   logic                  txp_fall;
   logic                  rxp_lvl;
   logic                  rxp_rise;
   logic                  rxp_fall;
   logic                  tx_raw;
   logic                  tx_raw_rise;
   logic                  tx_raw_fall;
   logic                  rx_raw;
   logic                  rx_raw_rise;
   logic                  rx_raw_fall;
   logic                  tx_base;
   logic                  tx_base_r;
   logic                  tx_base_f;
   logic                  rx_base;
   logic                  rx_base_r;
   logic                  rx_base_f;
   logic                  next_tx_pad;
   logic                  next_rx_pad;
   logic                  next_tx_oe;
   logic                  next_rx_oe;

   // APB slave answers with no wait states.
   assign pready  = 1'b1;
   assign pslverr = 1'b0;
   assign wr_en   = psel & penable & pwrite;
   assign rd_en   = psel & penable & ~pwrite;
   assign sr_read = rd_en && (paddr == SSCM_SR_OFS);

   // Configuration registers; each section has its own mode word.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clock_divider_config <= SSCM_DIV_RST;
         tx_clock_mode_config <= sscm_cm_t'(6'h00);
         rx_clock_mode_config <= sscm_cm_t'(6'h00);
         mask                 <= SSCM_IMR_RST;
      end else if (wr_en) begin
         case (paddr)
            SSCM_DIV_OFS:
               clock_divider_config <= pwdata[SSCM_DIV_W-1:0];
            SSCM_TXCM_OFS: begin
               tx_clock_mode_config.src      <= sscm_src_t'(
                  pwdata[SSCM_CKS_LSB +: 2]);
               tx_clock_mode_config.out_mode <= sscm_out_t'(
                  pwdata[SSCM_CKO_LSB +: 3]);
               tx_clock_mode_config.invert   <= pwdata[SSCM_CKI_BIT];
            end
            SSCM_RXCM_OFS: begin
               rx_clock_mode_config.src      <= sscm_src_t'(
                  pwdata[SSCM_CKS_LSB +: 2]);
               rx_clock_mode_config.out_mode <= sscm_out_t'(
                  pwdata[SSCM_CKO_LSB +: 3]);
               rx_clock_mode_config.invert   <= pwdata[SSCM_CKI_BIT];
            end
            SSCM_IMR_OFS:
               mask <= pwdata[SSCM_SR_W-1:0];
            default: ;
         endcase
      end
   end

   // Sticky status; a read clears only the bits it reported, so an event
   // landing in the setup cycle is not lost, and a new event always wins.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status <= 8'h00;
      end else if (sr_read) begin
         status <= (status & ~prdata[SSCM_SR_W-1:0]) | status_set;
      end else begin
         status <= status | status_set;
      end
   end

   // Read mux registers its data; unmapped offsets read as zero.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (psel && !penable && !pwrite) begin
         case (paddr)
            SSCM_DIV_OFS:  prdata <= {20'h00000, clock_divider_config};
            SSCM_TXCM_OFS: prdata <= {26'h0000000, tx_clock_mode_config};
            SSCM_RXCM_OFS: prdata <= {26'h0000000, rx_clock_mode_config};
            SSCM_SR_OFS:   prdata <= {24'h000000, status};
            SSCM_IMR_OFS:  prdata <= {24'h000000, mask};
            SSCM_STAT_OFS: prdata <= {26'h0000000, rx_clk, tx_clk,
                                      rxp_lvl, txp_lvl, div_clk, 1'b0};
            default:       prdata <= 32'h0000_0000;
         endcase
      end
   end

   // Interrupt from pending and enabled status.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status & mask);
      end
   end

   // Shared divider.
   sscm_div u_div (
      .pclk    (pclk),
      .presetn (presetn),
      .div     (clock_divider_config),
      .div_clk (div_clk),
      .div_rise(div_rise),
      .div_fall(div_fall)
   );

   // Pad clock synchronisers; the far party keeps its clock slow enough.
   sscm_sync u_txp (
      .pclk   (pclk),
      .presetn(presetn),
      .pad_i  (tx_clock_pin_i),
      .level  (txp_lvl),
      .rise   (txp_rise),
      .fall   (txp_fall)
   );

   sscm_sync u_rxp (
      .pclk   (pclk),
      .presetn(presetn),
      .pad_i  (rx_clock_pin_i),
      .level  (rxp_lvl),
      .rise   (rxp_rise),
      .fall   (rxp_fall)
   );

   // Base clocks from pad or divider; peer selection is resolved below so
   // a cross choice on both sides cannot form a loop.
   always_comb begin
      tx_base   = div_clk;
      tx_base_r = div_rise;
      tx_base_f = div_fall;
      rx_base   = div_clk;
      rx_base_r = div_rise;
      rx_base_f = div_fall;
      if (tx_clock_mode_config.src == SSCM_SRC_PAD) begin
         tx_base   = txp_lvl;
         tx_base_r = txp_rise;
         tx_base_f = txp_fall;
      end
      if (rx_clock_mode_config.src == SSCM_SRC_PAD) begin
         rx_base   = rxp_lvl;
         rx_base_r = rxp_rise;
         rx_base_f = rxp_fall;
      end
   end

   // Peer selection takes the other section's base clock.
   always_comb begin
      tx_raw      = tx_base;
      tx_raw_rise = tx_base_r;
      tx_raw_fall = tx_base_f;
      rx_raw      = rx_base;
      rx_raw_rise = rx_base_r;
      rx_raw_fall = rx_base_f;
      if (tx_clock_mode_config.src == SSCM_SRC_PEER) begin
         tx_raw      = rx_base;
         tx_raw_rise = rx_base_r;
         tx_raw_fall = rx_base_f;
      end
      if (rx_clock_mode_config.src == SSCM_SRC_PEER) begin
         rx_raw      = tx_base;
         rx_raw_rise = tx_base_r;
         rx_raw_fall = tx_base_f;
      end
   end

   // Internal clocks honour inversion; edge pulses swap with it.
   assign tx_clk      = tx_raw ^ tx_clock_mode_config.invert;
   assign tx_clk_rise = tx_clock_mode_config.invert ? tx_raw_fall
                                                    : tx_raw_rise;
   assign tx_clk_fall = tx_clock_mode_config.invert ? tx_raw_rise
                                                    : tx_raw_fall;
   assign rx_clk      = rx_raw ^ rx_clock_mode_config.invert;
   assign rx_clk_rise = rx_clock_mode_config.invert ? rx_raw_fall
                                                    : rx_raw_rise;
   assign rx_clk_fall = rx_clock_mode_config.invert ? rx_raw_rise
                                                    : rx_raw_fall;

   // Pad drive uses the uninverted clock; software must not mix pad source
   // with continuous output, which would drive back onto the sampled pad.
   always_comb begin
      next_tx_pad = tx_raw;
      next_rx_pad = rx_raw;
      next_tx_oe  = (tx_clock_mode_config.out_mode == SSCM_OUT_CONT) ||
                    ((tx_clock_mode_config.out_mode == SSCM_OUT_XFER) &&
                     tx_xfer);
      next_rx_oe  = (rx_clock_mode_config.out_mode == SSCM_OUT_CONT) ||
                    ((rx_clock_mode_config.out_mode == SSCM_OUT_XFER) &&
                     rx_xfer);
   end

   // Pad outputs come from flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tx_clock_pin_o  <= 1'b0;
         tx_clock_pin_oe <= 1'b0;
         rx_clock_pin_o  <= 1'b0;
         rx_clock_pin_oe <= 1'b0;
      end else begin
         tx_clock_pin_o  <= next_tx_pad & next_tx_oe;
         tx_clock_pin_oe <= next_tx_oe;
         rx_clock_pin_o  <= next_rx_pad & next_rx_oe;
         rx_clock_pin_oe <= next_rx_oe;
      end
   end

   // Assertions.
   property p_irq;
      @(posedge pclk) disable iff (!presetn)
         |(status & mask) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq missing");

   property p_noirq;
      @(posedge pclk) disable iff (!presetn)
         !(|(status & mask)) |=> !irq;
   endproperty
   a_noirq: assert property (p_noirq) else $error("irq spurious");

   property p_div0;
      @(posedge pclk) disable iff (!presetn)
         (clock_divider_config == 12'h000) [*2] |-> !div_rise;
   endproperty
   a_div0: assert property (p_div0) else $error("divider ran at 0");

   property p_div1;
      @(posedge pclk) disable iff (!presetn)
         (clock_divider_config == 12'h001) [*3] |-> $changed(div_clk);
   endproperty
   a_div1: assert property (p_div1) else $error("div 1 phase");

   property p_div2;
      @(posedge pclk) disable iff (!presetn)
         ((clock_divider_config == 12'h002) [*4] ##0 $rose(div_clk))
            |=> div_clk ##1 !div_clk;
   endproperty
   a_div2: assert property (p_div2) else $error("div 2 phase");

   property p_txoe;
      @(posedge pclk) disable iff (!presetn)
         (tx_clock_mode_config.out_mode == SSCM_OUT_NONE) |=> !tx_clock_pin_oe;
   endproperty
   a_txoe: assert property (p_txoe) else $error("tx pad driven");

   property p_rxoe;
      @(posedge pclk) disable iff (!presetn)
         (rx_clock_mode_config.out_mode == SSCM_OUT_CONT) |=> rx_clock_pin_oe;
   endproperty
   a_rxoe: assert property (p_rxoe) else $error("rx pad idle");

   property p_txpol;
      @(posedge pclk) disable iff (!presetn)
         (tx_clock_mode_config.out_mode == SSCM_OUT_CONT) |=>
            (tx_clock_pin_o == $past(tx_raw));
   endproperty
   a_txpol: assert property (p_txpol) else $error("tx pad pol");

endmodule
`default_nettype wire

// ---- tb/sscm_peer.sv ----
// Far-side serial peer model that drives a pad clock or rests it low.
`timescale 1ns/1ps
`default_nettype none
module sscm_peer #(
   parameter int HALF = 2
) (
   input  wire logic pclk,
   input  wire logic run,
   input  wire logic dut_o,
   input  wire logic dut_oe,
   output logic      pad
);
   logic [15:0] cnt   = 16'h0000;
   logic        clk_q = 1'b0;

   // Each level lasts HALF master cycles, never less than two, so the rate
   // stays at a quarter of the master clock or below; idle between frames.
   always @(posedge pclk) begin
      if (!run) begin
         cnt   <= 16'h0000;
         clk_q <= 1'b0;
      end else if (cnt == 16'(HALF - 1)) begin
         cnt   <= 16'h0000;
         clk_q <= ~clk_q;
      end else begin
         cnt <= cnt + 16'h0001;
      end
   end

   // The device owns the wire while it drives it; otherwise a stopped
   // clock rests low, so no edge appears outside a run.
   assign pad = dut_oe ? dut_o : clk_q;
endmodule
`default_nettype wire

// ---- tb/sscm_top_tb.sv ----
// Self-checking bench for the serial clock management block.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin \
   miscompares++; $display("FAIL %s exp %0h got %0h", n, e, g); end end
module sscm_top_tb
   import sscm_pkg::*;
;
   logic                 pclk       = 1'b0;
   logic                 presetn    = 1'b0;
   logic                 psel       = 1'b0;
   logic                 penable    = 1'b0;
   logic                 pwrite     = 1'b0;
   logic [7:0]           paddr      = 8'h00;
   logic [31:0]          pwdata     = 32'h0000_0000;
   logic [SSCM_SR_W-1:0] status_set = 8'h00;
   logic                 tx_xfer    = 1'b0;
   logic                 rx_xfer    = 1'b0;
   logic                 tx_run     = 1'b0;
   logic                 rx_run     = 1'b0;
   logic [31:0]          prdata;
   logic                 pready, pslverr, irq;
   logic                 tx_pad, tx_po, tx_poe, rx_pad, rx_po, rx_poe;
   logic                 tx_clk, tx_clk_rise, tx_clk_fall;
   logic                 rx_clk, rx_clk_rise, rx_clk_fall;
   int                   miscompares = 0;
   int                   tests_run   = 0;

   // The master clock runs at 125 MHz.
   always #4 pclk = ~pclk;

   sscm_top DUT (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .status_set(status_set),
      .tx_xfer(tx_xfer), .rx_xfer(rx_xfer), .tx_clock_pin_i(tx_pad),
      .tx_clock_pin_o(tx_po), .tx_clock_pin_oe(tx_poe),
      .rx_clock_pin_i(rx_pad), .rx_clock_pin_o(rx_po),
      .rx_clock_pin_oe(rx_poe), .tx_clk(tx_clk), .tx_clk_rise(tx_clk_rise),
      .tx_clk_fall(tx_clk_fall), .rx_clk(rx_clk), .rx_clk_rise(rx_clk_rise),
      .rx_clk_fall(rx_clk_fall), .irq(irq));

   sscm_peer #(.HALF(3)) tx_peer (.pclk(pclk), .run(tx_run),
      .dut_o(tx_po), .dut_oe(tx_poe), .pad(tx_pad));
   sscm_peer #(.HALF(2)) rx_peer (.pclk(pclk), .run(rx_run),
      .dut_o(rx_po), .dut_oe(rx_poe), .pad(rx_pad));

   task automatic tally_and_finish();
      if (miscompares == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // One APB transfer; the request holds until pready is seen high.
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      apb(1'b1, a, d, r);
   endtask

   task automatic rd_chk(input string n, input logic [7:0] a,
                         input logic [31:0] e);
      logic [31:0] d;
      apb(1'b0, a, 32'h0000_0000, d);
      `CHK(n, e, d)
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge pclk);
      #1;
   endtask

   function automatic logic [31:0] cm(input logic inv, input sscm_out_t o,
                                      input sscm_src_t s);
      return {26'h000_0000, inv, o, s};
   endfunction

   // Length of the current tx clock level; rx follows the same clock here.
   task automatic run_len(output int n);
      logic lvl;
      #1;
      lvl = tx_clk;
      n = 0;
      while (tx_clk === lvl && n < 9000) begin
         `CHK("rx_same", tx_clk, rx_clk)
         n++;
         tick(1);
      end
   endtask

   task automatic count_rises(input int w, output int nt, output int nr);
      nt = 0;
      nr = 0;
      repeat (w) begin
         tick(1);
         if (tx_clk_rise === 1'b1) begin
            nt++;
            `CHK("tx_rise_lvl", 1'b1, tx_clk)
         end
         if (rx_clk_rise === 1'b1) begin
            nr++;
            `CHK("rx_rise_lvl", 1'b1, rx_clk)
         end
      end
   endtask

   task automatic t_reset();
      logic [7:0] ofs[6] = '{SSCM_DIV_OFS, SSCM_TXCM_OFS, SSCM_RXCM_OFS,
                             SSCM_IMR_OFS, SSCM_SR_OFS, 8'h1C};
      `CHK("irq_rst", 1'b0, irq)
      `CHK("oe_rst", 1'b0, tx_poe | rx_poe)
      `CHK("pslverr", 1'b0, pslverr)
      foreach (ofs[i]) rd_chk("reset_val", ofs[i], 32'h0000_0000);
      wr(SSCM_DIV_OFS, 32'hFFFF_FFFF);
      rd_chk("div_width", SSCM_DIV_OFS, 32'h0000_0FFF);
      wr(8'h1C, 32'hFFFF_FFFF);
      rd_chk("unmapped", 8'h1C, 32'h0000_0000);
   endtask

   // The largest setting is included; short ones catch off-by-one counts.
   task automatic t_divider();
      int d[5] = '{1, 2, 3, 5, 4095};
      int a, b, nt, nr;
      wr(SSCM_TXCM_OFS, cm(1'b0, SSCM_OUT_NONE, SSCM_SRC_DIV));
      wr(SSCM_RXCM_OFS, cm(1'b0, SSCM_OUT_NONE, SSCM_SRC_DIV));
      foreach (d[i]) begin
         wr(SSCM_DIV_OFS, 32'(d[i]));
         run_len(a);
         run_len(a);
         run_len(b);
         `CHK("div_phase", d[i], a)
         `CHK("div_other", d[i], b)
      end
      wr(SSCM_DIV_OFS, 32'h0000_0000);
      tick(4);
      count_rises(50, nt, nr);
      `CHK("div_off", 0, nt + nr)
      `CHK("div_off_lvl", 1'b0, tx_clk)
      wr(SSCM_TXCM_OFS, cm(1'b1, SSCM_OUT_NONE, SSCM_SRC_DIV));
      rd_chk("live_state", SSCM_STAT_OFS, 32'h0000_0010);
   endtask

   task automatic t_invert();
      logic prev, pt;
      wr(SSCM_DIV_OFS, 32'h0000_0002);
      wr(SSCM_TXCM_OFS, cm(1'b1, SSCM_OUT_CONT, SSCM_SRC_DIV));
      wr(SSCM_RXCM_OFS, cm(1'b0, SSCM_OUT_CONT, SSCM_SRC_DIV));
      tick(4);
      prev = rx_clk;
      pt   = tx_clk;
      repeat (24) begin
         tick(1);
         `CHK("tx_inv", ~rx_clk, tx_clk)
         `CHK("tx_rise", tx_clk & ~pt, tx_clk_rise)
         `CHK("rx_fall", prev & ~rx_clk, rx_clk_fall)
         `CHK("tx_pad", prev, tx_po)
         `CHK("rx_pad", prev, rx_po)
         prev = rx_clk;
         pt   = tx_clk;
      end
      wr(SSCM_RXCM_OFS, cm(1'b1, SSCM_OUT_CONT, SSCM_SRC_DIV));
      tick(4);
      prev = ~rx_clk;
      repeat (8) begin
         tick(1);
         `CHK("rx_inv", tx_clk, rx_clk)
         `CHK("rx_pad_inv", prev, rx_po)
         prev = ~rx_clk;
      end
   endtask

   // Transfer flags are opposite on the two sides to show independence.
   task automatic t_outmode();
      sscm_out_t m[3] = '{SSCM_OUT_NONE, SSCM_OUT_CONT, SSCM_OUT_XFER};
      logic et, er;
      foreach (m[i]) begin
         for (int x = 0; x < 2; x++) begin
            wr(SSCM_TXCM_OFS, cm(1'b0, m[i], SSCM_SRC_DIV));
            wr(SSCM_RXCM_OFS, cm(1'b0, m[i], SSCM_SRC_DIV));
            tx_xfer <= x[0];
            rx_xfer <= ~x[0];
            tick(3);
            et = m[i] == SSCM_OUT_CONT || (m[i] == SSCM_OUT_XFER && x == 1);
            er = m[i] == SSCM_OUT_CONT || (m[i] == SSCM_OUT_XFER && x == 0);
            `CHK("tx_oe", et, tx_poe)
            `CHK("rx_oe", er, rx_poe)
            if (!et) `CHK("tx_idle", 1'b0, tx_po)
         end
      end
   endtask

   // Pad sources never use continuous drive, which would be unpredictable.
   task automatic t_pads();
      int nt, nr;
      wr(SSCM_RXCM_OFS, cm(1'b0, SSCM_OUT_NONE, SSCM_SRC_PAD));
      wr(SSCM_TXCM_OFS, cm(1'b0, SSCM_OUT_NONE, SSCM_SRC_PEER));
      rx_run <= 1'b1;
      tick(10);
      count_rises(84, nt, nr);
      `CHK("rx_pad_src", 21, nr)
      `CHK("tx_peer_src", 21, nt)
      wr(SSCM_TXCM_OFS, cm(1'b0, SSCM_OUT_NONE, SSCM_SRC_PAD));
      tx_run <= 1'b1;
      wr(SSCM_RXCM_OFS, cm(1'b0, SSCM_OUT_NONE, SSCM_SRC_PEER));
      tick(10);
      count_rises(84, nt, nr);
      `CHK("tx_pad_src", 14, nt)
      `CHK("rx_peer_src", 14, nr)
   endtask

   task automatic t_irq();
      wr(SSCM_IMR_OFS, 32'h0000_0004);
      rd_chk("mask", SSCM_IMR_OFS, 32'h0000_0004);
      @(posedge pclk);
      status_set <= 8'h04;
      @(posedge pclk);
      status_set <= 8'h00;
      tick(2);
      `CHK("irq_on", 1'b1, irq)
      rd_chk("cause", SSCM_SR_OFS, 32'h0000_0004);
      tick(2);
      `CHK("irq_off", 1'b0, irq)
      @(posedge pclk);
      status_set <= 8'h08;
      @(posedge pclk);
      status_set <= 8'h00;
      tick(3);
      `CHK("irq_masked", 1'b0, irq)
      rd_chk("masked_cause", SSCM_SR_OFS, 32'h0000_0008);
      rd_chk("cleared", SSCM_SR_OFS, 32'h0000_0000);
   endtask

   // Main sequence after an eight-cycle reset.
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_divider();
      t_invert();
      t_outmode();
      t_pads();
      t_irq();
      tally_and_finish();
   end

   // Watchdog sized well past the longest divider measurement.
   initial begin
      repeat (60000) @(posedge pclk);
      miscompares++;
      tally_and_finish();
   end
endmodule
`default_nettype wire
